// ---- design/rtcsf_pkg.sv ----
package rtcsf_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_RATE  = 7'h0A;
  localparam logic [ADDR_W-1:0] ADDR_MODE  = 7'h0B;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 7'h0C;
  localparam logic [ADDR_W-1:0] ADDR_BATT  = 7'h0D;

  // Mode/control field positions
  localparam int unsigned MODE_SET_BIT  = 7;
  localparam int unsigned MODE_PIE_BIT  = 6;
  localparam int unsigned MODE_AIE_BIT  = 5;
  localparam int unsigned MODE_UIE_BIT  = 4;
  localparam int unsigned MODE_SQUARE_WAVE_ENABLE_BIT = 3;
  localparam int unsigned MODE_BIN_BIT  = 2;
  localparam int unsigned MODE_H24_BIT  = 1;
  localparam int unsigned MODE_DSE_BIT  = 0;

  // Flag register field positions
  localparam int unsigned FLAG_ANY_BIT = 7;
  localparam int unsigned FLAG_PF_BIT  = 6;
  localparam int unsigned FLAG_AF_BIT  = 5;
  localparam int unsigned FLAG_UF_BIT  = 4;

  // Battery status field position
  localparam int unsigned BATT_GOOD_BIT = 7;

  // Rate select width and reset values
  localparam int unsigned RATE_W     = 4;
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [3:0]  RATE_RESET = 4'h0;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;

  // Calendar compare values, binary and BCD
  localparam logic [7:0] HOUR_ONE    = 8'h01;
  localparam logic [7:0] HOUR_TWO    = 8'h02;
  localparam logic [7:0] HOUR_THREE  = 8'h03;
  localparam logic [7:0] MS59_BIN    = 8'h3B;
  localparam logic [7:0] MS59_BCD    = 8'h59;
  localparam logic [7:0] MONTH_APR   = 8'h04;
  localparam logic [7:0] MONTH_OCT_B = 8'h0A;
  localparam logic [7:0] MONTH_OCT_D = 8'h10;
  localparam logic [7:0] WDAY_SUNDAY = 8'h01;
  localparam logic [7:0] DATE_WEEK1  = 8'h07;
  localparam logic [7:0] DATE_LAST_B = 8'h19;
  localparam logic [7:0] DATE_LAST_D = 8'h25;

endpackage : rtcsf_pkg

// ---- design/rtcsf_top.sv ----
`timescale 1ns/100ps
module rtcsf_top
  import rtcsf_pkg::*;
#(
  parameter int unsigned TAPS = 16
)(
  // Clock and power-on reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // External pins
  input  wire logic              rst_pin_n,
  input  wire logic              cell_ok,
  output logic                   irq_n,
  output logic                   sqw,
  // Divider and update logic
  input  wire logic [TAPS-1:0]   div_taps,
  input  wire logic              alarm_match,
  input  wire logic              update_tick,
  input  wire logic              update_done,
  // Current time from counters
  input  wire logic [7:0]        cur_sec,
  input  wire logic [7:0]        cur_min,
  input  wire logic [7:0]        cur_hour,
  input  wire logic [7:0]        cur_wday,
  input  wire logic [7:0]        cur_date,
  input  wire logic [7:0]        cur_month,
  // Control to counters
  output logic                   update_inhibit,
  output logic                   dst_load,
  output logic      [7:0]        dst_hour
);

  typedef struct packed {
    logic [7:0]        mode;
    logic [RATE_W-1:0] rate;
    logic              pf;
    logic              af;
    logic              uf;
    logic [7:0]        rdata;
    logic              tap_prev;
    logic              sqw;
    logic              rstp_s1;
    logic              rstp_s2;
    logic              cell_s1;
    logic              cell_s2;
    logic              dst_load;
    logic [7:0]        dst_hour;
    logic              fb_done;
  } rtcsf_state_s;

  // Pin synchroniser idles high, so no pin reset right after power-on
  localparam rtcsf_state_s Q_RESET = '{rstp_s1: 1'b1, rstp_s2: 1'b1, default: '0};

  rtcsf_state_s q;
  rtcsf_state_s d;

  logic       pin_rst;
  logic       tap_sel;
  logic       any_pend;
  logic [7:0] flags_rd;
  logic       at_159;
  logic       fwd_day;
  logic       back_day;
  logic       wr_mode;
  logic [7:0] ms59;
  logic [7:0] oct;
  logic [7:0] last_wk;

  always_comb
  begin
    pin_rst = ~q.rstp_s2;
    tap_sel = div_taps[q.rate];
    wr_mode = wr && (addr == ADDR_MODE);
    any_pend = (q.pf & q.mode[MODE_PIE_BIT]) | (q.af & q.mode[MODE_AIE_BIT])
             | (q.uf & q.mode[MODE_UIE_BIT]);
    flags_rd = ZERO_BYTE;
    flags_rd[FLAG_ANY_BIT] = any_pend;
    flags_rd[FLAG_PF_BIT]  = q.pf;
    flags_rd[FLAG_AF_BIT]  = q.af;
    flags_rd[FLAG_UF_BIT]  = q.uf;
    ms59    = q.mode[MODE_BIN_BIT] ? MS59_BIN : MS59_BCD;
    oct     = q.mode[MODE_BIN_BIT] ? MONTH_OCT_B : MONTH_OCT_D;
    last_wk = q.mode[MODE_BIN_BIT] ? DATE_LAST_B : DATE_LAST_D;
    at_159  = (cur_hour == HOUR_ONE) && (cur_min == ms59) && (cur_sec == ms59)
            && (cur_wday == WDAY_SUNDAY);
    fwd_day  = at_159 && (cur_month == MONTH_APR) && (cur_date <= DATE_WEEK1);
    back_day = at_159 && (cur_month == oct) && (cur_date >= last_wk);

    d = q;
    d.rstp_s1 = rst_pin_n;
    d.rstp_s2 = q.rstp_s1;
    d.cell_s1 = cell_ok;
    d.cell_s2 = q.cell_s1;
    d.tap_prev = tap_sel;
    d.sqw = q.mode[MODE_SQUARE_WAVE_ENABLE_BIT] & tap_sel & (q.rate != RATE_RESET);

    // Register writes; saving enable stored as written
    if (wr_mode)
    begin
      d.mode = wdata;
      // freeze going high clears update enable
      if (wdata[MODE_SET_BIT] && !q.mode[MODE_SET_BIT])
      begin
        d.mode[MODE_UIE_BIT] = 1'b0;
      end
    end
    if (wr && (addr == ADDR_RATE))
    begin
      d.rate = wdata[RATE_W-1:0];
    end

    // read clears, new event wins; read clear
    if (rd && (addr == ADDR_FLAGS))
    begin
      d.pf = 1'b0;
      d.af = 1'b0;
      d.uf = 1'b0;
    end
    // tap edge sets flag regardless of enable
    if (tap_sel && !q.tap_prev && (q.rate != RATE_RESET))
    begin
      d.pf = 1'b1;
    end
    if (alarm_match)
    begin
      d.af = 1'b1;
    end
    if (update_done)
    begin
      d.uf = 1'b1;
    end

    // reset pin clears interrupt and square-wave enables and flags
    if (pin_rst)
    begin
      d.mode[MODE_PIE_BIT]  = 1'b0;
      d.mode[MODE_AIE_BIT]  = 1'b0;
      d.mode[MODE_UIE_BIT]  = 1'b0;
      d.mode[MODE_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
      d.pf = 1'b0;
      d.af = 1'b0;
      d.uf = 1'b0;
    end

    // Read data, valid the cycle after the strobe
    d.rdata = ZERO_BYTE;
    if (rd)
    begin
      unique case (addr)
        ADDR_RATE:  d.rdata = {4'h0, q.rate};
        ADDR_MODE:  d.rdata = q.mode;
        ADDR_FLAGS: d.rdata = flags_rd;
        ADDR_BATT:  d.rdata = {q.cell_s2, 7'h00};
        default:    d.rdata = ZERO_BYTE;
      endcase
    end

    d.dst_load = q.mode[MODE_DSE_BIT] && (fwd_day || (back_day && !q.fb_done));
    d.dst_hour = fwd_day ? HOUR_THREE : HOUR_ONE;
    if (q.dst_load && update_tick && (q.dst_hour == HOUR_ONE))
    begin
      d.fb_done = 1'b1;
    end
    else if (cur_hour == HOUR_TWO)
    begin
      d.fb_done = 1'b0;
    end
  end

  // battery bit has no write path
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= Q_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata          = q.rdata;
  assign irq_n          = ~any_pend;
  assign sqw            = q.sqw;
  assign update_inhibit = q.mode[MODE_SET_BIT];
  assign dst_load       = q.dst_load;
  assign dst_hour       = q.dst_hour;

  a_irq_combined: assert property (@(posedge clk) disable iff (!nrst)
    irq_n == !((q.pf && q.mode[MODE_PIE_BIT]) || (q.af && q.mode[MODE_AIE_BIT])
               || (q.uf && q.mode[MODE_UIE_BIT])))
    else $error("interrupt output disagrees with flags");

  a_pf_tap_edge: assert property (@(posedge clk) disable iff (!nrst)
    (tap_sel && !q.tap_prev && q.rate != RATE_RESET && q.rstp_s2) |=> q.pf)
    else $error("periodic flag missed tap edge");

  a_flags_read_clear: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS && !alarm_match && !update_done
     && !(tap_sel && !q.tap_prev)) |=> (!q.pf && !q.af && !q.uf))
    else $error("flags not cleared by read");

  a_af_sets: assert property (@(posedge clk) disable iff (!nrst)
    (alarm_match && q.rstp_s2) |=> q.af)
    else $error("alarm flag not set");

  a_uf_sets: assert property (@(posedge clk) disable iff (!nrst)
    (update_done && q.rstp_s2) |=> q.uf)
    else $error("update flag not set");

  a_flags_read_old: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS) |=> (rdata[FLAG_UF_BIT] == $past(q.uf)
      && rdata[3:0] == 4'h0 && rdata[FLAG_PF_BIT] == $past(q.pf)))
    else $error("flag read returned wrong value");

  a_batt_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_BATT) |=> (rdata == {$past(q.cell_s2), 7'h00}))
    else $error("battery register read wrong");

  a_freeze_uie: assert property (@(posedge clk) disable iff (!nrst)
    (wr_mode && wdata[MODE_SET_BIT] && !q.mode[MODE_SET_BIT])
      |=> !q.mode[MODE_UIE_BIT])
    else $error("freeze did not clear update enable");

  a_pin_rst_en: assert property (@(posedge clk) disable iff (!nrst)
    (!q.rstp_s2) |=> (!q.mode[MODE_PIE_BIT] && !q.mode[MODE_AIE_BIT] && !q.pf))
    else $error("reset pin did not clear enables");

  a_dse_kept: assert property (@(posedge clk) disable iff (!nrst)
    !wr_mode |=> $stable(q.mode[MODE_DSE_BIT]))
    else $error("saving enable changed without write");

  a_dst_gate: assert property (@(posedge clk) disable iff (!nrst)
    !q.mode[MODE_DSE_BIT] |=> !dst_load)
    else $error("daylight jump with saving disabled");

  a_dst_spring: assert property (@(posedge clk) disable iff (!nrst)
    (q.mode[MODE_DSE_BIT] && fwd_day) |=> (dst_load && dst_hour == HOUR_THREE))
    else $error("spring jump not offered");

  a_fall_back: assert property (@(posedge clk) disable iff (!nrst)
    (q.mode[MODE_DSE_BIT] && back_day && !fwd_day && !q.fb_done)
      |=> (dst_load && dst_hour == HOUR_ONE))
    else $error("autumn jump not offered");

  a_fall_mark: assert property (@(posedge clk) disable iff (!nrst)
    (q.dst_load && update_tick && q.dst_hour == HOUR_ONE) |=> q.fb_done)
    else $error("autumn jump not marked done");

  a_fall_once: assert property (@(posedge clk) disable iff (!nrst)
    (q.fb_done && !fwd_day) |=> !dst_load)
    else $error("autumn jump repeated");

  a_dst_off_season: assert property (@(posedge clk) disable iff (!nrst)
    (!fwd_day && !back_day) |=> !dst_load)
    else $error("daylight jump outside its weekend");

  a_pf_only_edge: assert property (@(posedge clk) disable iff (!nrst)
    (!q.pf && !(tap_sel && !q.tap_prev)) |=> !q.pf)
    else $error("periodic flag set without tap edge");

  a_pf_rate_off: assert property (@(posedge clk) disable iff (!nrst)
    (!q.pf && q.rate == RATE_RESET) |=> !q.pf)
    else $error("periodic flag set with rate off");

  a_pf_read_clear: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS && !(tap_sel && !q.tap_prev)) |=> !q.pf)
    else $error("periodic flag not cleared by read");

  a_af_only_match: assert property (@(posedge clk) disable iff (!nrst)
    (!q.af && !alarm_match) |=> !q.af)
    else $error("alarm flag set without match");

  a_af_irq: assert property (@(posedge clk) disable iff (!nrst)
    (alarm_match && q.mode[MODE_AIE_BIT] && !wr_mode && q.rstp_s2) |=> !irq_n)
    else $error("enabled alarm did not raise interrupt");

  a_af_read_clear: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS && !alarm_match) |=> !q.af)
    else $error("alarm flag not cleared by read");

  a_uf_only_done: assert property (@(posedge clk) disable iff (!nrst)
    (!q.uf && !update_done) |=> !q.uf)
    else $error("update flag set without update end");

  a_uf_irq: assert property (@(posedge clk) disable iff (!nrst)
    (update_done && q.mode[MODE_UIE_BIT] && !wr_mode && q.rstp_s2) |=> !irq_n)
    else $error("enabled update end did not raise interrupt");

  a_uf_read_clear: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS && !update_done) |=> !q.uf)
    else $error("update flag not cleared by read");

  a_pin_rst_flags: assert property (@(posedge clk) disable iff (!nrst)
    (!q.rstp_s2) |=> (!q.af && !q.uf && !q.mode[MODE_UIE_BIT] && !q.mode[MODE_SQUARE_WAVE_ENABLE_BIT]))
    else $error("reset pin did not clear flags");

  a_any_bit_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS) |=> (rdata[FLAG_ANY_BIT] == !$past(irq_n)))
    else $error("combined flag disagrees with interrupt");

  a_af_read_old: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS) |=> (rdata[FLAG_AF_BIT] == $past(q.af)))
    else $error("alarm flag read wrong");

  a_event_wins: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_FLAGS && update_done && q.rstp_s2) |=> q.uf)
    else $error("update event lost during flag read");

  a_batt_pin_rst: assert property (@(posedge clk) disable iff (!nrst)
    (!q.rstp_s2) |=> (q.cell_s2 == $past(q.cell_s1)))
    else $error("battery bit disturbed by reset pin");

  a_pie_kept: assert property (@(posedge clk) disable iff (!nrst)
    (!wr_mode && q.rstp_s2) |=> $stable(q.mode[MODE_PIE_BIT]))
    else $error("periodic enable changed by itself");

  a_aie_kept: assert property (@(posedge clk) disable iff (!nrst)
    (!wr_mode && q.rstp_s2) |=> $stable(q.mode[MODE_AIE_BIT]))
    else $error("alarm enable changed by itself");

  a_uie_kept: assert property (@(posedge clk) disable iff (!nrst)
    (!wr_mode && q.rstp_s2) |=> $stable(q.mode[MODE_UIE_BIT]))
    else $error("update enable changed by itself");

  a_mode_read: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_MODE) |=> (rdata == $past(q.mode)))
    else $error("mode register read wrong");

  a_dse_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_mode |=> (q.mode[MODE_DSE_BIT] == $past(wdata[MODE_DSE_BIT])))
    else $error("saving enable not written");

  a_flags_wr_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (wr && addr == ADDR_FLAGS && !q.uf && !update_done) |=> !q.uf)
    else $error("flag register took a write");

  a_set_kept: assert property (@(posedge clk) disable iff (!nrst)
    !wr_mode |=> $stable(update_inhibit))
    else $error("freeze bit changed without write");

  a_batt_low_zero: assert property (@(posedge clk) disable iff (!nrst)
    (rd && addr == ADDR_BATT) |=> (rdata[6:0] == 7'h00))
    else $error("battery register low bits not zero");

endmodule // rtcsf_top

// ---- tb/rtcsf_div_model.sv ----
`timescale 1ns/100ps
module rtcsf_div_model #(
  parameter int unsigned TAPS = 16
)(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // Divider control and taps
  input  wire logic            run,
  output logic      [TAPS-1:0] taps
);
  // Divider chain advances only while running
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      taps <= '0;
    else if (run)
      taps <= taps + 1'b1;
  end
endmodule // rtcsf_div_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb
  import rtcsf_pkg::*;
;
  logic              clk, nrst, wr, rd, rst_pin_n, cell_ok, run, irq_n, sqw;
  logic              alarm_match, update_done, update_tick, update_inhibit, dst_load;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata, rdata, dst_hour, cur_hour, cur_date, cur_month;
  logic [15:0]       div_taps;
  int                failures, tests_run, cycles;

  rtcsf_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rst_pin_n(rst_pin_n), .cell_ok(cell_ok), .irq_n(irq_n),
    .sqw(sqw), .div_taps(div_taps), .alarm_match(alarm_match), .update_tick(update_tick),
    .update_done(update_done), .cur_sec(8'h59), .cur_min(8'h59), .cur_hour(cur_hour),
    .cur_wday(8'h01), .cur_date(cur_date), .cur_month(cur_month),
    .update_inhibit(update_inhibit), .dst_load(dst_load), .dst_hour(dst_hour));

  rtcsf_div_model i_div (.clk(clk), .nrst(nrst), .run(run), .taps(div_taps));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  task automatic pulse(input bit alarm, input logic irq_exp);
    @(posedge clk);
    if (alarm)
      alarm_match <= 1'b1;
    else
      update_done <= 1'b1;
    @(posedge clk);
    alarm_match <= 1'b0;
    update_done <= 1'b0;
    #1 chk("irq_n", {7'h00, irq_exp}, {7'h00, irq_n});
  endtask

  task automatic periodic(input int n);
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
  endtask

  task automatic dst_at(input logic [7:0] mon, input logic [7:0] day);
    @(posedge clk);
    cur_month <= mon;
    cur_date  <= day;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial
  begin
    {nrst, wr, rd, run, alarm_match, update_done, update_tick} = '0;
    {rst_pin_n, cell_ok} = 2'b11;
    addr = '0;
    wdata = 8'h00;
    cur_hour = 8'h01;
    cur_date = 8'h01;
    cur_month = 8'h01;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(ADDR_MODE, 8'h00);
    rd_reg(ADDR_BATT, 8'h80);
    rd_reg(7'h05, 8'h00);
    wr_reg(ADDR_FLAGS, 8'hFF);
    wr_reg(ADDR_BATT, 8'h00);
    rd_reg(ADDR_FLAGS, 8'h00);
    rd_reg(ADDR_BATT, 8'h80);
    wr_reg(ADDR_MODE, 8'h11);
    rd_reg(ADDR_MODE, 8'h11);
    pulse(1'b0, 1'b0);
    rd_reg(ADDR_FLAGS, 8'h90);
    rd_reg(ADDR_FLAGS, 8'h00);
    pulse(1'b1, 1'b1);
    rd_reg(ADDR_FLAGS, 8'h20);
    rd_reg(ADDR_FLAGS, 8'h00);
    wr_reg(ADDR_MODE, 8'h31);
    pulse(1'b1, 1'b0);
    rd_reg(ADDR_FLAGS, 8'hA0);
    @(posedge clk);
    addr        <= ADDR_FLAGS;
    rd          <= 1'b1;
    update_done <= 1'b1;
    @(posedge clk);
    rd          <= 1'b0;
    update_done <= 1'b0;
    #1 chk("rdata", 8'h00, rdata);
    rd_reg(ADDR_FLAGS, 8'h90);
    wr_reg(ADDR_RATE, 8'h01);
    periodic(6);
    rd_reg(ADDR_FLAGS, 8'h40);
    rd_reg(ADDR_FLAGS, 8'h00);
    wr_reg(ADDR_MODE, 8'h71);
    periodic(6);
    #1 chk("irq_n", 8'h00, {7'h00, irq_n});
    rd_reg(ADDR_FLAGS, 8'hC0);
    dst_at(8'h04, 8'h05);
    chk("dst_load", 8'h01, {7'h00, dst_load});
    chk("dst_hour", 8'h03, dst_hour);
    dst_at(8'h10, 8'h27);
    chk("dst_hour", 8'h01, dst_hour);
    chk("dst_load", 8'h01, {7'h00, dst_load});
    @(posedge clk);
    update_tick <= 1'b1;
    @(posedge clk);
    update_tick <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("dst_load", 8'h00, {7'h00, dst_load});
    @(posedge clk);
    cur_hour <= 8'h02;
    @(posedge clk);
    cur_hour <= 8'h01;
    dst_at(8'h10, 8'h27);
    chk("dst_load", 8'h01, {7'h00, dst_load});
    wr_reg(ADDR_MODE, 8'h70);
    dst_at(8'h10, 8'h27);
    chk("dst_load", 8'h00, {7'h00, dst_load});
    wr_reg(ADDR_MODE, 8'h91);
    rd_reg(ADDR_MODE, 8'h81);
    chk("update_inhibit", 8'h01, {7'h00, update_inhibit});
    wr_reg(ADDR_RATE, 8'h02);
    wr_reg(ADDR_MODE, 8'h09);
    @(posedge clk);
    #1 chk("sqw", 8'h01, {7'h00, sqw});
    chk("update_inhibit", 8'h00, {7'h00, update_inhibit});
    wr_reg(ADDR_MODE, 8'h71);
    pulse(1'b0, 1'b0);
    @(posedge clk);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(ADDR_MODE, 8'h01);
    rd_reg(ADDR_FLAGS, 8'h00);
    rd_reg(ADDR_BATT, 8'h80);
    @(posedge clk);
    cell_ok <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_BATT, 8'h00);
    wrap_up();
  end
endmodule // tb
